// *** rtl/baud_and_master_watchdog.sv ***
// watchdog for a fieldbus slave: rate hunt, rate watch, master watch
// assumes frame receiver pulses are synchronous, one cycle wide
//
// Notes on behaviour
// - reset always enters the rate hunt
// - hunt starts at the highest bit rate
// - no good frame in time: next lower rate, lowest wraps to highest
// - good frame ends hunt, enter rate watch
// - rate watch time is reload times 10 ms
// - good own-address frame restarts rate watch timer
// - rate watch expiry returns to hunt
// - parameter frame with offload and enable set: enter master watch
// - enable clear keeps rate watch
// - rate watch expiry leaves protocol machine alone
// - master watch time is factor A*B*base
// - watch factors accepted from 1 to 255
// - master expiry: rate watch, irq, protocol reset
// - new master in master watch: enable picks master or rate watch
`default_nettype none
module baud_and_master_watchdog (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       good_frame_i,
  input  wire logic       own_addr_frame_i,
  input  wire logic       master_frame_i,
  input  wire logic       param_frame_i,
  input  wire logic       master_watch_enable_i,
  input  wire logic       new_master_i,
  input  wire logic       protocol_offload_enable_i,
  input  wire logic [7:0] rate_watch_reload_i,
  input  wire logic [7:0] hunt_time_i,
  input  wire logic [7:0] watch_factor_a_i,
  input  wire logic [7:0] watch_factor_b_i,
  input  wire logic       base_1ms_i,
  output logic      [3:0] rate_sel_o,
  output logic      [1:0] watch_state_machine_o,
  output logic            master_watch_state_o,
  output logic            master_watch_timeout_irq_o,
  output logic            protocol_reset_o
);
  typedef struct packed {
    rate_watch_pkg::watch_state_t st;
    logic [3:0]                   rate;
    logic [15:0]                  div;
    logic [3:0]                   ten;
    logic [19:0]                  cnt;
    logic [7:0]                   fa;
    logic [7:0]                   fb;
    logic                         ms1;
    logic                         irq;
    logic                         prst;
    logic                         mws;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic   tick;
  logic   base_tick;

  // product of the factors; zero factors read as one
  function automatic logic [19:0] fact_load(input logic [7:0] a,
                                            input logic [7:0] b);
    logic [7:0] aa;
    logic [7:0] bb;
    aa = (a == 8'h00) ? 8'h01 : a;
    bb = (b == 8'h00) ? 8'h01 : b;
    // widen before multiplying so 255*255 keeps all of its bits
    fact_load = 20'(16'(aa) * 16'(bb));
  endfunction

  // counter load for the current state, in base ticks
  function automatic logic [19:0] load_for(
      input rate_watch_pkg::watch_state_t st, input logic [7:0] rel,
      input logic [7:0] hunt, input logic [7:0] a, input logic [7:0] b);
    if (st == rate_watch_pkg::ST_MASTER) begin
      load_for = fact_load(a, b);
    end else if (st == rate_watch_pkg::ST_RATE) begin
      load_for = {12'h000, (rel == 8'h00) ? 8'h01 : rel};
    end else begin
      load_for = {12'h000, (hunt == 8'h00) ? 8'h01 : hunt};
    end
  endfunction

  // 1 ms tick and the selected time base tick
  always_comb begin
    tick = (s_reg.div == 16'(rate_watch_pkg::TICK_1MS_CYC - 1));
    base_tick = tick && (s_reg.ms1 || s_reg.st != rate_watch_pkg::ST_MASTER
                || s_reg.ten == 4'(rate_watch_pkg::BASE_10MS_TICKS - 1))
                && (s_reg.st == rate_watch_pkg::ST_MASTER ||
                s_reg.ten == 4'(rate_watch_pkg::BASE_10MS_TICKS - 1));
  end

  // next-state logic of the whole watchdog
  always_comb begin
    s_next = s_reg;
    s_next.irq = 1'b0;
    s_next.prst = 1'b0;
    s_next.div = tick ? 16'h0000 : s_reg.div + 16'h0001;
    if (tick) begin
      s_next.ten = (s_reg.ten == 4'(rate_watch_pkg::BASE_10MS_TICKS - 1))
                   ? 4'h0 : s_reg.ten + 4'h1;
    end
    if (base_tick && s_reg.cnt != 20'h00000) begin
      s_next.cnt = s_reg.cnt - 20'h00001;
    end
    case (s_reg.st)
      rate_watch_pkg::ST_HUNT: begin
        if (good_frame_i) begin
          s_next.st = rate_watch_pkg::ST_RATE;
          s_next.cnt = load_for(rate_watch_pkg::ST_RATE, rate_watch_reload_i,
                                hunt_time_i, s_reg.fa, s_reg.fb);
        end else if (base_tick && s_reg.cnt <= 20'h00001) begin
          s_next.rate = (s_reg.rate == rate_watch_pkg::RATE_LOWEST)
                        ? rate_watch_pkg::RATE_HIGHEST
                        : s_reg.rate + 4'h1;
          s_next.cnt = load_for(rate_watch_pkg::ST_HUNT, rate_watch_reload_i,
                                hunt_time_i, s_reg.fa, s_reg.fb);
        end
      end
      rate_watch_pkg::ST_RATE: begin
        if (param_frame_i && protocol_offload_enable_i
            && master_watch_enable_i) begin
          s_next.st = rate_watch_pkg::ST_MASTER;
          s_next.fa = watch_factor_a_i;
          s_next.fb = watch_factor_b_i;
          s_next.ms1 = base_1ms_i;
          s_next.ten = 4'h0;
          s_next.cnt = fact_load(watch_factor_a_i, watch_factor_b_i);
        end else if (good_frame_i && own_addr_frame_i) begin
          s_next.cnt = load_for(rate_watch_pkg::ST_RATE, rate_watch_reload_i,
                                hunt_time_i, s_reg.fa, s_reg.fb);
        end else if (base_tick && s_reg.cnt <= 20'h00001) begin
          s_next.st = rate_watch_pkg::ST_HUNT;
          s_next.rate = rate_watch_pkg::RATE_HIGHEST;
          s_next.cnt = load_for(rate_watch_pkg::ST_HUNT, rate_watch_reload_i,
                                hunt_time_i, s_reg.fa, s_reg.fb);
        end
      end
      rate_watch_pkg::ST_MASTER: begin
        if (new_master_i && !master_watch_enable_i) begin
          s_next.st = rate_watch_pkg::ST_RATE;
          s_next.cnt = load_for(rate_watch_pkg::ST_RATE, rate_watch_reload_i,
                                hunt_time_i, s_reg.fa, s_reg.fb);
        end else if ((good_frame_i && own_addr_frame_i && master_frame_i)
                     || new_master_i) begin
          s_next.cnt = fact_load(s_reg.fa, s_reg.fb);
        end else if (base_tick && s_reg.cnt <= 20'h00001) begin
          s_next.st = rate_watch_pkg::ST_RATE;
          s_next.irq = 1'b1;
          s_next.prst = 1'b1;
          s_next.cnt = load_for(rate_watch_pkg::ST_RATE, rate_watch_reload_i,
                                hunt_time_i, s_reg.fa, s_reg.fb);
        end
      end
      default: begin
        s_next.st = rate_watch_pkg::ST_HUNT;
      end
    endcase
    // registered copy so the level output comes from a flop
    s_next.mws = (s_next.st == rate_watch_pkg::ST_MASTER);
  end

  // single state register; reset lands in hunt at top rate
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_reg.st   <= rate_watch_pkg::ST_HUNT;
      s_reg.rate <= rate_watch_pkg::RATE_HIGHEST;
      s_reg.div  <= 16'h0000;
      s_reg.ten  <= 4'h0;
      s_reg.cnt  <= 20'h00001;
      s_reg.fa   <= rate_watch_pkg::FACT_RESET;
      s_reg.fb   <= rate_watch_pkg::FACT_RESET;
      s_reg.ms1  <= 1'b0;
      s_reg.irq  <= 1'b0;
      s_reg.prst <= 1'b0;
      s_reg.mws  <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  always_comb begin
    rate_sel_o                 = s_reg.rate;
    watch_state_machine_o      = s_reg.st;
    master_watch_state_o       = s_reg.mws;
    master_watch_timeout_irq_o = s_reg.irq;
    protocol_reset_o           = s_reg.prst;
  end

  // checks on the state machine, all on the state register's clock
  AST_HUNT_ADVANCES: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_HUNT && !good_frame_i && base_tick
    && s_reg.cnt == 20'h00001 && s_reg.rate != rate_watch_pkg::RATE_LOWEST
    |=> s_reg.rate == $past(s_reg.rate) + 4'h1)
    else $error("hunt did not step down");
  AST_HUNT_WRAP: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_HUNT && !good_frame_i && base_tick
    && s_reg.cnt == 20'h00001 && s_reg.rate == rate_watch_pkg::RATE_LOWEST
    |=> s_reg.rate == rate_watch_pkg::RATE_HIGHEST)
    else $error("hunt did not wrap");
  AST_FOUND: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_HUNT && good_frame_i
    |=> s_reg.st == rate_watch_pkg::ST_RATE)
    else $error("good frame did not end hunt");
  AST_RATE_EXPIRE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_RATE && base_tick && s_reg.cnt == 20'h1
    && !good_frame_i && !param_frame_i
    |=> s_reg.st == rate_watch_pkg::ST_HUNT && !protocol_reset_o
    && rate_sel_o == rate_watch_pkg::RATE_HIGHEST)
    else $error("rate watch expiry wrong");
  AST_ENTER_MASTER: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_RATE && param_frame_i
    && protocol_offload_enable_i && master_watch_enable_i
    |=> master_watch_state_o)
    else $error("master watch not entered");
  AST_STAY_RATE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_RATE && !master_watch_enable_i
    |=> !master_watch_state_o)
    else $error("left rate watch while disabled");
  AST_MASTER_EXPIRE: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    master_watch_state_o && base_tick && s_reg.cnt == 20'h1 && !new_master_i
    && !good_frame_i |=> master_watch_timeout_irq_o && protocol_reset_o
    && s_reg.st == rate_watch_pkg::ST_RATE ##1 !master_watch_timeout_irq_o)
    else $error("master expiry wrong");
  AST_RATE_RESTART: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_RATE && good_frame_i && own_addr_frame_i
    && !param_frame_i |=> s_reg.cnt == {12'h000, $past(rate_watch_reload_i)}
    || $past(rate_watch_reload_i) == 8'h00)
    else $error("rate watch not restarted");
  // a frame from the master reloads the full product of the factors
  AST_MASTER_RESTART: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_MASTER && good_frame_i && own_addr_frame_i
    && master_frame_i && !new_master_i && s_reg.fa != 8'h00
    && s_reg.fb != 8'h00
    |=> s_reg.cnt == 20'(16'(s_reg.fa) * 16'(s_reg.fb)))
    else $error("master watch not restarted");
  COV_FOUND: cover property (@(posedge clk_i) disable iff (!resetn_i)
    s_reg.st == rate_watch_pkg::ST_HUNT ##1 s_reg.st == rate_watch_pkg::ST_RATE);
  COV_MASTER: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(master_watch_state_o));
  COV_IRQ: cover property (@(posedge clk_i) disable iff (!resetn_i)
    master_watch_timeout_irq_o);
endmodule
`default_nettype wire

// *** rtl/rate_watch_pkg.sv ***
// constants for the bit rate hunt and master watch timer
// assumes a 50 MHz system clock and synchronous inputs
`default_nettype none
package rate_watch_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned TICK_1MS_US     = 1000;
  // cycles of one 1 ms tick, derived from the clock rate
  localparam int unsigned TICK_1MS_CYC    = CLK_HZ / 1000000 * TICK_1MS_US;
  localparam int unsigned TICK_DIV_W      = 16;
  localparam int unsigned BASE_10MS_TICKS = 10;
  localparam int unsigned RATE_W          = 4;
  localparam logic [3:0]  RATE_HIGHEST    = 4'h0;
  localparam logic [3:0]  RATE_LOWEST     = 4'h9;
  localparam int unsigned CNT_W           = 20;
  localparam int unsigned FACT_W          = 8;
  localparam logic [7:0]  FACT_RESET      = 8'h01;
  localparam logic [7:0]  RELOAD_RESET    = 8'h01;

  typedef enum logic [1:0] {
    ST_HUNT   = 2'b00,
    ST_RATE   = 2'b01,
    ST_MASTER = 2'b10
  } watch_state_t;
endpackage
`default_nettype wire

// *** dv/frame_source_model.sv ***
// frame receiver model: one-cycle frame pulses towards the watchdog
// assumes the watchdog clock; the bench calls its tasks by hierarchy
`default_nettype none
module frame_source_model (
  input  wire logic       clk_i,
  output logic            good_frame_o,
  output logic            own_addr_frame_o,
  output logic            master_frame_o,
  output logic            param_frame_o,
  output logic            new_master_o,
  output logic            master_watch_enable_o,
  output logic      [7:0] watch_factor_a_o,
  output logic      [7:0] watch_factor_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet bus until the first frame
  initial begin
    {good_frame_o, own_addr_frame_o, master_frame_o} = 3'h0;
    {param_frame_o, new_master_o, master_watch_enable_o} = 3'h0;
    watch_factor_a_o = 8'h01;
    watch_factor_b_o = 8'h02;
  end
  // error-free frame, qualifiers held with the pulse
  task automatic send_good(input logic own, input logic mst);
    @(posedge clk_i);
    good_frame_o <= 1'b1;
    own_addr_frame_o <= own;
    master_frame_o <= mst;
    @(posedge clk_i);
    good_frame_o <= 1'b0;
  endtask
  // parameter frame; factors 1 and 1 are never sent, b goes to 2
  task automatic send_param(input logic en, input logic [7:0] a,
                            input logic [7:0] b);
    @(posedge clk_i);
    param_frame_o <= 1'b1;
    master_watch_enable_o <= en;
    watch_factor_a_o <= a;
    watch_factor_b_o <= (a == 8'h01 && b == 8'h01) ? 8'h02 : b;
    @(posedge clk_i);
    param_frame_o <= 1'b0;
  endtask
  // takeover by a different master
  task automatic send_new_master(input logic en);
    @(posedge clk_i);
    new_master_o <= 1'b1;
    master_watch_enable_o <= en;
    @(posedge clk_i);
    new_master_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/baud_and_master_watchdog_tb.sv ***
// bench for the rate hunt and master watch timer
// assumes the 1 ms tick of 50000 cycles held in the package
`default_nettype none
module baud_and_master_watchdog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, resetn_i, offload, base_1ms, good, own, mst, par;
  logic       nm, en, irq, prst, mws;
  logic [7:0] reload, hunt, fa, fb;
  logic [3:0] rate;
  logic [1:0] st;
  int         error_cnt, comparisons, n;
  frame_source_model src (.clk_i(clk_i), .good_frame_o(good),
    .own_addr_frame_o(own), .master_frame_o(mst), .param_frame_o(par),
    .new_master_o(nm), .master_watch_enable_o(en),
    .watch_factor_a_o(fa), .watch_factor_b_o(fb));
  baud_and_master_watchdog dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .good_frame_i(good), .own_addr_frame_i(own), .master_frame_i(mst),
    .param_frame_i(par), .master_watch_enable_i(en), .new_master_i(nm),
    .protocol_offload_enable_i(offload), .rate_watch_reload_i(reload),
    .hunt_time_i(hunt), .watch_factor_a_i(fa), .watch_factor_b_i(fb),
    .base_1ms_i(base_1ms), .rate_sel_o(rate),
    .watch_state_machine_o(st), .master_watch_state_o(mws),
    .master_watch_timeout_irq_o(irq), .protocol_reset_o(prst));
  // free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cut a hang short: the longest wait is two 1 ms ticks
  initial begin
    repeat (101000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
  task automatic settle();
    #1;
  endtask
  initial begin
    error_cnt = 0;
    comparisons = 0;
    resetn_i = 1'b0;
    offload = 1'b0;
    base_1ms = 1'b1;
    reload = 8'h05;
    hunt = 8'h03;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    settle();
    check(st, 32'h0);
    check(rate, 32'h0);
    // a good frame ends the hunt on the next cycle
    src.send_good(1'b1, 1'b0);
    settle();
    check(st, 32'h1);
    check(rate, 32'h0);
    // an own-address frame in rate watch restarts the timer, no change
    src.send_good(1'b1, 1'b0);
    settle();
    check(st, 32'h1);
    // parameter frames: two that must leave rate watch alone, then one that enters master watch
    src.send_param(1'b1, 8'h01, 8'h02);
    settle();
    check(st, 32'h1);
    @(posedge clk_i);
    offload <= 1'b1;
    src.send_param(1'b0, 8'h01, 8'h02);
    settle();
    check(st, 32'h1);
    check(mws, 32'h0);
    src.send_param(1'b1, 8'h01, 8'h02);
    settle();
    check(st, 32'h2);
    check(mws, 32'h1);
    // takeover keeps or drops master watch by the enable bit
    src.send_new_master(1'b1);
    settle();
    check(st, 32'h2);
    src.send_good(1'b1, 1'b1);
    settle();
    check(st, 32'h2);
    src.send_new_master(1'b0);
    settle();
    check(st, 32'h1);
    // two 1 ms ticks of master watch, then expiry
    src.send_param(1'b1, 8'h01, 8'h02);
    n = 0;
    while (irq !== 1'b1 && n < 100010) begin
      @(posedge clk_i);
      settle();
      n++;
    end
    check(n > rate_watch_pkg::TICK_1MS_CYC
          && n <= 2 * rate_watch_pkg::TICK_1MS_CYC, 32'h1);
    check(prst, 32'h1);
    @(posedge clk_i);
    settle();
    check(st, 32'h1);
    check(irq, 32'h0);
    check(mws, 32'h0);
    // reset in mid-run returns to the hunt at the top rate
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    settle();
    check(st, 32'h0);
    check(rate, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    settle();
    check(st, 32'h0);
    check(mws, 32'h0);
    check(irq, 32'h0);
    check(prst, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
